// ### rtl/adc_port_pkg.sv
// constants and types for the six-channel converter read port
package adc_port_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CONV_TIME_NS = 3200;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam int NUM_PAIRS = 3;
	localparam int NUM_CH = 6;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [7:0] SOFT_IN_RST = 8'h00;
	localparam logic [2:0] CH_FIRST = 3'h0;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic byte_split;
		logic direct_addr;
		logic [2:0] sel;
	} bus_ctrl_s;

	typedef struct packed {
		logic [15:0] data_out;
		logic [15:0] data_oe_n;
	} bus_drive_s;
endpackage : adc_port_pkg

// ### rtl/pair_converter.sv
// one channel pair: freeze capture, conversion timer and result latch
`default_nettype none
module pair_converter
	import adc_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pair_sample_freeze_n,
	input wire logic [15:0] sample_ch0,
	input wire logic [15:0] sample_ch1,
	output logic [15:0] result_ch0,
	output logic [15:0] result_ch1,
	output logic done
);
	typedef enum logic [1:0] {IDLE, CONVERT, WAIT_HIGH} conv_state_e;
	conv_state_e state;
	logic [CNT_W-1:0] count;
	logic [15:0] held0;
	logic [15:0] held1;
	wire logic last = (count == CNT_W'(CONV_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= IDLE;
			count <= '0;
			held0 <= RESULT_RST;
			held1 <= RESULT_RST;
			result_ch0 <= RESULT_RST;
			result_ch1 <= RESULT_RST;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state)
				IDLE:
					if (!pair_sample_freeze_n)
					begin
						held0 <= sample_ch0;
						held1 <= sample_ch1;
						count <= '0;
						state <= CONVERT;
					end
				CONVERT:
					if (last)
					begin
						result_ch0 <= held0;
						result_ch1 <= held1;
						done <= 1'b1;
						state <= WAIT_HIGH;
					end
					else
						count <= count + CNT_W'(1);
				WAIT_HIGH:
					if (pair_sample_freeze_n)
						state <= IDLE;
				default:
					state <= IDLE;
			endcase
		end
	end

	conv_time_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(pair_sample_freeze_n) && state == IDLE |-> ##129 done)
		else $error("conversion did not complete on time");
endmodule : pair_converter
`default_nettype wire

// ### rtl/adc_parallel_port.sv
// converter control and parallel read port top
`default_nettype none
module adc_parallel_port
	import adc_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pair_a_sample_freeze_n,
	input wire logic pair_b_sample_freeze_n,
	input wire logic pair_c_sample_freeze_n,
	input wire logic [NUM_CH*16-1:0] sample_in,
	input wire adc_port_pkg::bus_ctrl_s ctrl,
	input wire logic [7:0] parallel_bus_in,
	output adc_port_pkg::bus_drive_s drive,
	output logic [7:0] soft_input,
	output logic eoc_n,
	output logic first_word_flag
);
	import adc_port_pkg::*;
	wire logic [NUM_PAIRS-1:0] freeze_n = {pair_c_sample_freeze_n, pair_b_sample_freeze_n, pair_a_sample_freeze_n};
	logic [15:0] results [NUM_CH];
	logic [NUM_PAIRS-1:0] done;
	logic eoc_half;
	logic [2:0] ch_sel;
	logic [15:0] word;
	logic rd_prev;
	logic wr_prev;

	genvar p;
	generate
		for (p = 0; p < NUM_PAIRS; p++)
		begin : g_pair
			pair_converter u_pair (
				.clk(clk),
				.rst_n(rst_n),
				.pair_sample_freeze_n(freeze_n[p]),
				.sample_ch0(sample_in[(2*p)*16 +: 16]),
				.sample_ch1(sample_in[(2*p+1)*16 +: 16]),
				.result_ch0(results[2*p]),
				.result_ch1(results[2*p+1]),
				.done(done[p])
			);
		end
	endgenerate

	wire logic read_active = !ctrl.cs_n && !ctrl.rd_n;
	wire logic rd_fall = read_active && rd_prev;
	wire logic wr_fall = !ctrl.cs_n && !ctrl.wr_n && wr_prev;
	wire logic [2:0] next_ch = (ch_sel == 3'h5) ? CH_FIRST : ch_sel + 3'h1;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ch_sel <= CH_FIRST;
			rd_prev <= 1'b1;
			wr_prev <= 1'b1;
			soft_input <= SOFT_IN_RST;
			word <= RESULT_RST;
			eoc_half <= 1'b0;
		end
		else
		begin
			rd_prev <= !read_active;
			wr_prev <= ctrl.cs_n || ctrl.wr_n;
			eoc_half <= |done;
			if (rd_fall)
			begin
				word <= results[ctrl.direct_addr ? ctrl.sel : ch_sel];
				ch_sel <= ctrl.direct_addr ? ctrl.sel : next_ch;
			end
			if (wr_fall)
				soft_input <= parallel_bus_in;
		end
	end

	// low for half a period after latch
	assign eoc_n = !(eoc_half && !clk);
	assign first_word_flag = read_active && (ch_sel == CH_FIRST) && rd_fall;

	// full word, upper byte low, combinational
	assign drive.data_out = ctrl.byte_split ? {8'h00, word[15:8]} : word;
	assign drive.data_oe_n = read_active ? (ctrl.byte_split ? 16'hFF00 : 16'h0000) : 16'hFFFF;

	eoc_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		|done |=> eoc_half)
		else $error("completion not flagged");
	split_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		read_active && ctrl.byte_split |-> drive.data_out[7:0] == word[15:8])
		else $error("upper byte not on low lines");
	full_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		read_active && !ctrl.byte_split |-> drive.data_out == word && drive.data_oe_n == 16'h0000)
		else $error("full word not driven");
	idle_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		!read_active |-> drive.data_oe_n == 16'hFFFF)
		else $error("bus driven outside read");
	direct_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_fall && ctrl.direct_addr |=> ch_sel == $past(ctrl.sel))
		else $error("direct address not taken");
	soft_in_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_fall |=> soft_input == $past(parallel_bus_in))
		else $error("write bits not captured");
	reset_a: assert property (@(posedge clk)
		!rst_n |=> ch_sel == CH_FIRST && soft_input == SOFT_IN_RST)
		else $error("reset state wrong");
	byte_swap_a: assert property (@(posedge clk) disable iff (!rst_n)
		read_active && $changed(ctrl.byte_split) |-> drive.data_out[7:0] == (ctrl.byte_split ? word[15:8] : word[7:0]))
		else $error("bus did not follow byte split");

	first_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_fall && ch_sel == CH_FIRST |-> first_word_flag)
		else $error("first word flag missing");

	first_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		!read_active |-> !first_word_flag)
		else $error("first word flag outside read");

	seq_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_fall && !ctrl.direct_addr |=> ch_sel == (($past(ch_sel) == 3'h5) ? CH_FIRST : $past(ch_sel) + 3'h1))
		else $error("sequential pointer did not step");

	word_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!rd_fall |=> $stable(word))
		else $error("read word changed without strobe");

	soft_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!wr_fall |=> $stable(soft_input))
		else $error("write bits changed without strobe");

	byte_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
		read_active && ctrl.byte_split |-> drive.data_oe_n == 16'hFF00 && drive.data_out[15:8] == 8'h00)
		else $error("upper lines not released in byte mode");

	eoc_src_a: assert property (@(posedge clk) disable iff (!rst_n)
		eoc_half |-> $past(|done))
		else $error("completion pulse without latch");

	write_c: cover property (@(posedge clk) disable iff (!rst_n) wr_fall);
	direct_c: cover property (@(posedge clk) disable iff (!rst_n) rd_fall && ctrl.direct_addr);

	conv_done_c: cover property (@(posedge clk) disable iff (!rst_n) done[0]);
	read_c: cover property (@(posedge clk) disable iff (!rst_n) rd_fall);
	split_c: cover property (@(posedge clk) disable iff (!rst_n) read_active && ctrl.byte_split);
endmodule : adc_parallel_port
`default_nettype wire

// ### tb/host_model.sv
// host side model: freeze requests, read and write strobes
`default_nettype none
module host_model
	import adc_port_pkg::*;
(
	input wire logic clk,
	output logic [2:0] freeze_n,
	output adc_port_pkg::bus_ctrl_s ctrl,
	output logic [7:0] bus_in
);
	timeunit 1ns;
	timeprecision 100ps;
	import adc_port_pkg::*;
	logic [2:0] all_high = 3'h7;
	initial
	begin
		freeze_n = all_high;
		ctrl = 8'hE0;
		bus_in = 8'h00;
	end
	task automatic freeze(input logic [2:0] m);
	begin
		@(posedge clk) freeze_n <= ~m;
		@(posedge clk) freeze_n <= all_high;
	end
	endtask : freeze
	task automatic rd_on(input logic d, input logic [2:0] s);
	begin
		@(posedge clk) ctrl <= {3'h7, 1'b0, d, s};
		@(posedge clk) ctrl.cs_n <= 1'b0;
		ctrl.rd_n <= 1'b0;
	end
	endtask : rd_on
	task automatic rd_off;
	begin
		@(posedge clk) ctrl.rd_n <= 1'b1;
		@(posedge clk) ctrl.cs_n <= 1'b1;
	end
	endtask : rd_off
	// byte mode toggled under a held strobe
	task automatic set_byte(input logic b);
	begin
		@(posedge clk) ctrl.byte_split <= b;
	end
	endtask : set_byte
	task automatic wr(input logic [7:0] v);
	begin
		@(posedge clk) bus_in <= v;
		ctrl <= 8'h40;
		repeat (2) @(posedge clk);
		ctrl <= 8'hE0;
		bus_in <= ~v;
	end
	endtask : wr
endmodule : host_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the converter read port
`default_nettype none
module tb
	import adc_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] fz_n;
	adc_port_pkg::bus_ctrl_s ctrl;
	logic [7:0] bus_in;
	logic [95:0] smp = 96'h6C01_5B02_4A03_3904_2805_1706;
	adc_port_pkg::bus_drive_s drive;
	logic [7:0] soft_input;
	logic eoc_n;
	logic fwf;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	host_model h_u (.clk(clk), .freeze_n(fz_n), .ctrl(ctrl), .bus_in(bus_in));
	adc_parallel_port dut_u (.clk(clk), .rst_n(rst_n), .pair_a_sample_freeze_n(fz_n[0]),
		.pair_b_sample_freeze_n(fz_n[1]), .pair_c_sample_freeze_n(fz_n[2]), .sample_in(smp),
		.ctrl(ctrl), .parallel_bus_in(bus_in), .drive(drive), .soft_input(soft_input),
		.eoc_n(eoc_n), .first_word_flag(fwf));
	always #12.5 clk = ~clk;
	task automatic end_sim;
	begin
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask : end_sim
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			end_sim();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
	begin
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	end
	endtask : check
	task automatic rd(input logic d, input logic [2:0] s, input logic [15:0] e, input logic f);
	begin
		h_u.rd_on(d, s);
		@(negedge clk);
		if (!d)
			check(16'(fwf), 16'(f));
		repeat (2) @(posedge clk);
		#1;
		check(drive.data_out, e);
		check(drive.data_oe_n, 16'h0000);
	end
	endtask : rd
	task automatic t_conv_seq;
	begin
		h_u.freeze(3'h7);
		for (int n = 0; n < 400 && eoc_n !== 1'b0; n++)
			@(negedge clk) #1;
		check(16'(eoc_n), 16'h0000);
		@(posedge clk) #1;
		check(16'(eoc_n), 16'h0001);
		for (int k = 0; k < 6; k++)
		begin
			rd(1'b0, 3'h0, smp[16*k +: 16], k == 0);
			h_u.rd_off();
		end
	end
	endtask : t_conv_seq
	task automatic t_direct;
	begin
		for (int k = 5; k >= 0; k--)
		begin
			rd(1'b1, 3'(k), smp[16*k +: 16], 1'b0);
			h_u.rd_off();
		end
	end
	endtask : t_direct
	task automatic t_byte;
	begin
		rd(1'b1, 3'h3, smp[63:48], 1'b0);
		h_u.set_byte(1'b1);
		#1;
		check({drive.data_oe_n[15:8], drive.data_out[7:0]}, {8'hFF, smp[63:56]});
		h_u.set_byte(1'b0);
		#1;
		check(drive.data_out, smp[63:48]);
		h_u.rd_off();
	end
	endtask : t_byte
	task automatic t_write_reset;
	begin
		h_u.wr(8'h5A);
		@(posedge clk) #1;
		check({8'h00, soft_input}, 16'h005A);
		@(posedge clk) rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check({8'h00, soft_input}, {8'h00, SOFT_IN_RST});
		rd(1'b1, CH_FIRST, RESULT_RST, 1'b0);
		h_u.rd_off();
	end
	endtask : t_write_reset
	// reset four cycles, one idle cycle before freeze
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_conv_seq();
		t_direct();
		t_byte();
		t_write_reset();
		end_sim();
	end
endmodule : tb
`default_nettype wire
